// ==== src/gpcd_pin_mux.sv ====
// per-port pin driver: input, output or display function per pin
`timescale 1ns/1ps
module gpcd_pin_mux
#(
  parameter int unsigned PINS     = 16,
  parameter logic [15:0] ALT_MASK = 16'hffff
)
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [2*PINS-1:0] func,
  input  wire logic [PINS-1:0]   data,
  input  wire logic [PINS-1:0]   alt_out,
  input  wire logic [PINS-1:0]   alt_oe,
  output logic      [PINS-1:0]   pin_out,
  output logic      [PINS-1:0]   pin_oe
);

  if (PINS != gpcd_pkg::GPCD_PINS)
  begin : g_chk
    $error("gpcd_pin_mux: PINS must be 16");
  end

  logic [PINS-1:0] out_r;
  logic [PINS-1:0] out_nxt;
  logic [PINS-1:0] oe_r;
  logic [PINS-1:0] oe_nxt;

  always_comb
  begin
    out_nxt = '0;
    oe_nxt  = '0;
    for (int unsigned i = 0; i < PINS; i++)
    begin
      unique case (gpcd_pkg::gpcd_pin_mode(32'(func), i))
        gpcd_pkg::GPCD_MODE_OUT:
        begin
          out_nxt[i] = data[i]; // see RULE_06
          oe_nxt[i]  = 1'b1;
        end
        gpcd_pkg::GPCD_MODE_ALT:
        begin
          out_nxt[i] = alt_out[i] & ALT_MASK[i]; // see RULE_02
          oe_nxt[i]  = alt_oe[i] & ALT_MASK[i];  // see RULE_04
        end
        gpcd_pkg::GPCD_MODE_IN,
        gpcd_pkg::GPCD_MODE_RSV:
        begin
          out_nxt[i] = 1'b0;
          oe_nxt[i]  = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      out_r <= '0;
      oe_r  <= '0;
    end
    else
    begin
      out_r <= out_nxt;
      oe_r  <= oe_nxt;
    end
  end

  assign pin_out = out_r;
  assign pin_oe  = oe_r;

endmodule

// ==== src/gpcd_pkg.sv ====
// shared constants, types and decode functions of the port c/d gpio block
package gpcd_pkg;

  // ------------------------------------------------------------
  // register byte addresses
  // ------------------------------------------------------------
  localparam logic [31:0] GPCD_PC_FUNC_ADDR  = 32'h5600_0020;
  localparam logic [31:0] GPCD_PC_DATA_ADDR  = 32'h5600_0024;
  localparam logic [31:0] GPCD_PC_PULL_ADDR  = 32'h5600_0028;
  localparam logic [31:0] GPCD_PC_SPARE_ADDR = 32'h5600_002c;
  localparam logic [31:0] GPCD_PD_FUNC_ADDR  = 32'h5600_0030;
  localparam logic [31:0] GPCD_PD_DATA_ADDR  = 32'h5600_0034;
  localparam logic [31:0] GPCD_PD_PULL_ADDR  = 32'h5600_0038;
  localparam logic [31:0] GPCD_PD_SPARE_ADDR = 32'h5600_003c;

  // ------------------------------------------------------------
  // field layout and reset values
  // ------------------------------------------------------------
  localparam int unsigned GPCD_PINS       = 16;
  localparam int unsigned GPCD_FIELD_W    = 2;
  localparam int unsigned GPCD_DATA_LSB   = 0;
  localparam int unsigned GPCD_PULL_DN_BIT = 0;
  localparam int unsigned GPCD_PULL_UP_BIT = 1;
  localparam logic [31:0] GPCD_FUNC_RST   = 32'h0000_0000;
  localparam logic [15:0] GPCD_DATA_RST   = 16'h0000;
  localparam logic [31:0] GPCD_PULL_RST   = 32'h0555_5555;
  localparam logic [31:0] GPCD_RDATA_RST  = 32'h0000_0000;

  // pins whose code 10 selects a real display signal
  localparam logic [15:0] GPCD_PC_ALT_MASK = 16'hff1f;
  localparam logic [15:0] GPCD_PD_ALT_MASK = 16'hffff;

  // ------------------------------------------------------------
  // pin modes
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    GPCD_MODE_IN  = 2'b00,
    GPCD_MODE_OUT = 2'b01,
    GPCD_MODE_ALT = 2'b10,
    GPCD_MODE_RSV = 2'b11
  } gpcd_mode_t;

  function automatic gpcd_mode_t gpcd_pin_mode
  (
    input logic [31:0] func,
    input int unsigned pin
  );
    return gpcd_mode_t'(func[GPCD_FIELD_W*pin +: GPCD_FIELD_W]);
  endfunction

  // data register read value: pin level unless driven as output
  function automatic logic [15:0] gpcd_readback
  (
    input logic [31:0] func,
    input logic [15:0] data,
    input logic [15:0] level
  );
    logic [15:0] val;
    val = level;
    for (int unsigned i = 0; i < GPCD_PINS; i++)
    begin
      if (gpcd_pin_mode(func, i) == GPCD_MODE_OUT)
      begin
        val[i] = data[i];
      end
    end
    return val;
  endfunction

endpackage

// ==== src/gpcd_sync.sv ====
// two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module gpcd_sync
#(
  parameter int unsigned WIDTH = 16
)
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  if (WIDTH < 1)
  begin : g_chk
    $error("gpcd_sync: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] sync_nxt;

  always_comb
  begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else
    begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r;

endmodule

// ==== src/gpcd_top.sv ====
// port c and port d gpio: registers, pin drivers and display functions
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
// Overview of operation
// RULE_01: port c function register: 16 two-bit fields, 00 in, 01 out, reset 0.
// RULE_02: port c code 10: pins 8-15 video data 0-7, pins 0-4 panel controls.
// RULE_03: port d function register: same fields, reset 0, all pins inputs.
// RULE_04: port d code 10: pins 0-15 carry video data bits 8 to 23.
// RULE_05: reading data bit of an input pin returns the pin level.
// RULE_06: output pin is driven with its data register bit.
// RULE_07: alternate-function pin data read value is unspecified.
// RULE_08: port c data register: bits 15:0 data, upper bits reserved, reset 0.
// RULE_09: port d data register: bits 15:0 data, upper bits reserved, reset 0.
// RULE_10: pull fields: upper bit pull-up, lower pull-down, 11 gives no pull.
// RULE_11: port c pull register resets to 0x5555555, pull-down pins 0-13.
// RULE_12: port d pull register resets to the same pattern.
// RULE_13: reserved words and bits read zero, writes to them are ignored.
// RULE_14: input levels pass two flops before reaching the read value.
module gpcd_top
(
  input  wire logic        MCLK,
  input  wire logic        SYS_RST,
  input  wire logic [31:0] REG_ADDR,
  input  wire logic [31:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [31:0] REG_RDATA,
  input  wire logic [15:0] PORTC_PIN_IN,
  output logic      [15:0] PORTC_PIN_OUT,
  output logic      [15:0] PORTC_PIN_OE,
  output logic      [15:0] PORTC_PULL_UP,
  output logic      [15:0] PORTC_PULL_DOWN,
  input  wire logic [15:0] PORTD_PIN_IN,
  output logic      [15:0] PORTD_PIN_OUT,
  output logic      [15:0] PORTD_PIN_OE,
  output logic      [15:0] PORTD_PULL_UP,
  output logic      [15:0] PORTD_PULL_DOWN,
  input  wire logic [23:0] PIXEL_VIDEO_DATA,
  input  wire logic        VIDEO_DATA_OE,
  output logic      [23:0] VIDEO_DATA_IN,
  input  wire logic        PIXEL_DATA_ENABLE,
  input  wire logic        VERTICAL_SYNC_OUT,
  input  wire logic        HORIZONTAL_SYNC_OUT,
  input  wire logic        PIXEL_CLOCK_OUT,
  input  wire logic        LINE_END_OUT
);

  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  logic [31:0] pc_func_r;
  logic [31:0] pc_func_nxt;
  logic [15:0] pc_data_r;
  logic [15:0] pc_data_nxt;
  logic [31:0] pc_pull_r;
  logic [31:0] pc_pull_nxt;
  logic [31:0] pd_func_r;
  logic [31:0] pd_func_nxt;
  logic [15:0] pd_data_r;
  logic [15:0] pd_data_nxt;
  logic [31:0] pd_pull_r;
  logic [31:0] pd_pull_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  // ------------------------------------------------------------
  // pull drive state
  // ------------------------------------------------------------
  logic [15:0] pc_up_r;
  logic [15:0] pc_up_nxt;
  logic [15:0] pc_dn_r;
  logic [15:0] pc_dn_nxt;
  logic [15:0] pd_up_r;
  logic [15:0] pd_up_nxt;
  logic [15:0] pd_dn_r;
  logic [15:0] pd_dn_nxt;

  // ------------------------------------------------------------
  // synchronised pin levels and display signal routing
  // ------------------------------------------------------------
  logic [15:0] pc_level;
  logic [15:0] pd_level;
  logic [15:0] pc_alt_out;
  logic [15:0] pc_alt_oe;
  logic [15:0] pd_alt_out;
  logic [15:0] pd_alt_oe;

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  gpcd_sync
  #(
    .WIDTH (16)
  )
  u_pc_sync
  (
    .clk      (MCLK),
    .rst      (SYS_RST),
    .async_in (PORTC_PIN_IN),
    .sync_out (pc_level)
  ); // see RULE_14

  gpcd_sync
  #(
    .WIDTH (16)
  )
  u_pd_sync
  (
    .clk      (MCLK),
    .rst      (SYS_RST),
    .async_in (PORTD_PIN_IN),
    .sync_out (pd_level)
  ); // see RULE_14

  // ------------------------------------------------------------
  // display function routing
  // ------------------------------------------------------------
  // port c: pins 8-15 video 0-7, pins 5-7 none, pins 0-4 controls
  assign pc_alt_out = {PIXEL_VIDEO_DATA[7:0], 3'h0,
                       PIXEL_DATA_ENABLE, VERTICAL_SYNC_OUT,
                       HORIZONTAL_SYNC_OUT, PIXEL_CLOCK_OUT,
                       LINE_END_OUT}; // see RULE_02
  assign pc_alt_oe  = {{8{VIDEO_DATA_OE}}, 3'h0, 5'h1f};
  // port d: pins 0-15 video 8-23
  assign pd_alt_out = PIXEL_VIDEO_DATA[23:8]; // see RULE_04
  assign pd_alt_oe  = {16{VIDEO_DATA_OE}};
  // panel read-back path towards the display controller
  assign VIDEO_DATA_IN = {pd_level, pc_level[15:8]};

  // ------------------------------------------------------------
  // pin drivers
  // ------------------------------------------------------------
  gpcd_pin_mux
  #(
    .PINS     (16),
    .ALT_MASK (gpcd_pkg::GPCD_PC_ALT_MASK)
  )
  u_pc_mux
  (
    .clk     (MCLK),
    .rst     (SYS_RST),
    .func    (pc_func_r),
    .data    (pc_data_r),
    .alt_out (pc_alt_out),
    .alt_oe  (pc_alt_oe),
    .pin_out (PORTC_PIN_OUT),
    .pin_oe  (PORTC_PIN_OE)
  ); // see RULE_01

  gpcd_pin_mux
  #(
    .PINS     (16),
    .ALT_MASK (gpcd_pkg::GPCD_PD_ALT_MASK)
  )
  u_pd_mux
  (
    .clk     (MCLK),
    .rst     (SYS_RST),
    .func    (pd_func_r),
    .data    (pd_data_r),
    .alt_out (pd_alt_out),
    .alt_oe  (pd_alt_oe),
    .pin_out (PORTD_PIN_OUT),
    .pin_oe  (PORTD_PIN_OE)
  ); // see RULE_03

  // ------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------
  always_comb
  begin
    pc_func_nxt = pc_func_r;
    pc_data_nxt = pc_data_r;
    pc_pull_nxt = pc_pull_r;
    pd_func_nxt = pd_func_r;
    pd_data_nxt = pd_data_r;
    pd_pull_nxt = pd_pull_r;
    if (REG_WR)
    begin
      unique case (REG_ADDR)
        gpcd_pkg::GPCD_PC_FUNC_ADDR: pc_func_nxt = REG_WDATA; // see RULE_01
        gpcd_pkg::GPCD_PC_DATA_ADDR: pc_data_nxt = REG_WDATA[15:0]; // see RULE_08
        gpcd_pkg::GPCD_PC_PULL_ADDR: pc_pull_nxt = REG_WDATA; // see RULE_10
        gpcd_pkg::GPCD_PD_FUNC_ADDR: pd_func_nxt = REG_WDATA; // see RULE_03
        gpcd_pkg::GPCD_PD_DATA_ADDR: pd_data_nxt = REG_WDATA[15:0]; // see RULE_09
        gpcd_pkg::GPCD_PD_PULL_ADDR: pd_pull_nxt = REG_WDATA; // see RULE_10
        default:
        begin
          // spare words and unmapped addresses: write dropped
          pc_func_nxt = pc_func_r; // see RULE_13
        end
      endcase
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      pc_func_r <= gpcd_pkg::GPCD_FUNC_RST; // see RULE_01
      pc_data_r <= gpcd_pkg::GPCD_DATA_RST; // see RULE_08
      pc_pull_r <= gpcd_pkg::GPCD_PULL_RST; // see RULE_11
      pd_func_r <= gpcd_pkg::GPCD_FUNC_RST; // see RULE_03
      pd_data_r <= gpcd_pkg::GPCD_DATA_RST; // see RULE_09
      pd_pull_r <= gpcd_pkg::GPCD_PULL_RST; // see RULE_12
    end
    else
    begin
      pc_func_r <= pc_func_nxt;
      pc_data_r <= pc_data_nxt;
      pc_pull_r <= pc_pull_nxt;
      pd_func_r <= pd_func_nxt;
      pd_data_r <= pd_data_nxt;
      pd_pull_r <= pd_pull_nxt;
    end
  end

  // ------------------------------------------------------------
  // register reads
  // ------------------------------------------------------------
  always_comb
  begin
    rdata_nxt = gpcd_pkg::GPCD_RDATA_RST;
    if (REG_RD)
    begin
      unique case (REG_ADDR)
        gpcd_pkg::GPCD_PC_FUNC_ADDR: rdata_nxt = pc_func_r;
        gpcd_pkg::GPCD_PC_DATA_ADDR:
        begin
          // alternate pins return the pin level, see RULE_07
          rdata_nxt[15:0] = gpcd_pkg::gpcd_readback(pc_func_r,
                              pc_data_r, pc_level); // see RULE_05
        end
        gpcd_pkg::GPCD_PC_PULL_ADDR: rdata_nxt = pc_pull_r;
        gpcd_pkg::GPCD_PD_FUNC_ADDR: rdata_nxt = pd_func_r;
        gpcd_pkg::GPCD_PD_DATA_ADDR:
        begin
          rdata_nxt[15:0] = gpcd_pkg::gpcd_readback(pd_func_r,
                              pd_data_r, pd_level); // see RULE_05
        end
        gpcd_pkg::GPCD_PD_PULL_ADDR: rdata_nxt = pd_pull_r;
        default:
        begin
          rdata_nxt = gpcd_pkg::GPCD_RDATA_RST; // see RULE_13
        end
      endcase
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      rdata_r <= gpcd_pkg::GPCD_RDATA_RST;
    end
    else
    begin
      rdata_r <= rdata_nxt;
    end
  end

  assign REG_RDATA = rdata_r;

  // ------------------------------------------------------------
  // pull control decode
  // ------------------------------------------------------------
  always_comb
  begin
    pc_up_nxt = '0;
    pc_dn_nxt = '0;
    pd_up_nxt = '0;
    pd_dn_nxt = '0;
    for (int unsigned i = 0; i < gpcd_pkg::GPCD_PINS; i++)
    begin
      // code 11 is not available: neither pull is turned on
      pc_up_nxt[i] = pc_pull_r[2*i+gpcd_pkg::GPCD_PULL_UP_BIT]
                   & ~pc_pull_r[2*i+gpcd_pkg::GPCD_PULL_DN_BIT]; // see RULE_10
      pc_dn_nxt[i] = pc_pull_r[2*i+gpcd_pkg::GPCD_PULL_DN_BIT]
                   & ~pc_pull_r[2*i+gpcd_pkg::GPCD_PULL_UP_BIT];
      pd_up_nxt[i] = pd_pull_r[2*i+gpcd_pkg::GPCD_PULL_UP_BIT]
                   & ~pd_pull_r[2*i+gpcd_pkg::GPCD_PULL_DN_BIT];
      pd_dn_nxt[i] = pd_pull_r[2*i+gpcd_pkg::GPCD_PULL_DN_BIT]
                   & ~pd_pull_r[2*i+gpcd_pkg::GPCD_PULL_UP_BIT];
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      pc_up_r <= 16'h0000;
      pc_dn_r <= 16'h0000;
      pd_up_r <= 16'h0000;
      pd_dn_r <= 16'h0000;
    end
    else
    begin
      pc_up_r <= pc_up_nxt;
      pc_dn_r <= pc_dn_nxt;
      pd_up_r <= pd_up_nxt;
      pd_dn_r <= pd_dn_nxt;
    end
  end

  assign PORTC_PULL_UP   = pc_up_r;
  assign PORTC_PULL_DOWN = pc_dn_r;
  assign PORTD_PULL_UP   = pd_up_r;
  assign PORTD_PULL_DOWN = pd_dn_r;

endmodule

// ==== test/gpcd_board.sv ====
// board pin model: external drivers, pulls and floating lines
`timescale 1ns/1ps
module gpcd_board
(
  input  wire logic        clk,
  input  wire logic [15:0] pin_out,
  input  wire logic [15:0] pin_oe,
  input  wire logic [15:0] pull_up,
  input  wire logic [15:0] pull_down,
  input  wire logic [15:0] drv,
  input  wire logic [15:0] drv_en,
  output logic      [15:0] level
);
  logic [15:0] float_r = 16'h5a5a;
  always @(posedge clk)
    float_r <= ~float_r;
  // device drive wins, then board, then pulls, else floating
  always_comb
    level = (pin_oe & pin_out) | (~pin_oe & drv_en & drv)
      | (~pin_oe & ~drv_en & (pull_up | (~pull_down & float_r)));
endmodule

// ==== test/gpcd_top_properties.sv ====
// checker of the port c/d gpio block, with its bind
`timescale 1ns/1ps
module gpcd_chk
(
  input wire logic        MCLK,
  input wire logic        SYS_RST,
  input wire logic [31:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic        REG_WR,
  input wire logic        REG_RD,
  input wire logic [31:0] REG_RDATA,
  input wire logic [15:0] PORTC_PIN_IN,
  input wire logic [15:0] PORTC_PIN_OUT,
  input wire logic [15:0] PORTC_PIN_OE,
  input wire logic [15:0] PORTC_PULL_UP,
  input wire logic [15:0] PORTC_PULL_DOWN,
  input wire logic [15:0] PORTD_PIN_IN,
  input wire logic [15:0] PORTD_PULL_UP,
  input wire logic [15:0] PORTD_PULL_DOWN,
  input wire logic [23:0] VIDEO_DATA_IN
);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  wire logic [7:0]  pc_hi = PORTC_PIN_IN[15:8];
  wire logic [15:0] wd_lo = REG_WDATA[15:0];
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);

  property p_rd_idle;
    !$past(REG_RD) |-> REG_RDATA == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero outside answer");
  property p_spare;
    REG_RD && (REG_ADDR == gpcd_pkg::GPCD_PC_SPARE_ADDR ||
    REG_ADDR == gpcd_pkg::GPCD_PD_SPARE_ADDR) |=> REG_RDATA == 32'h0;
  endproperty
  a_spare: assert property (p_spare)
    else $error("spare word read not zero");
  property p_dat_hi;
    REG_RD && (REG_ADDR == gpcd_pkg::GPCD_PC_DATA_ADDR ||
    REG_ADDR == gpcd_pkg::GPCD_PD_DATA_ADDR) |=> REG_RDATA[31:16] == 16'h0;
  endproperty
  a_dat_hi: assert property (p_dat_hi)
    else $error("data upper bits not zero");
  property p_pull_c;
    (PORTC_PULL_UP & PORTC_PULL_DOWN) == 16'h0;
  endproperty
  a_pull_c: assert property (p_pull_c)
    else $error("port c both pulls on");
  property p_pull_d;
    (PORTD_PULL_UP & PORTD_PULL_DOWN) == 16'h0;
  endproperty
  a_pull_d: assert property (p_pull_d)
    else $error("port d both pulls on");
  property p_rst_c;
    $fell(SYS_RST) |=> PORTC_PULL_DOWN == 16'h3fff && PORTC_PULL_UP == 16'h0;
  endproperty
  a_rst_c: assert property (p_rst_c)
    else $error("port c pull reset wrong");
  property p_rst_d;
    $fell(SYS_RST) |=> PORTD_PULL_DOWN == 16'h3fff && PORTD_PULL_UP == 16'h0;
  endproperty
  a_rst_d: assert property (p_rst_d)
    else $error("port d pull reset wrong");
  property p_c_in;
    REG_WR && REG_ADDR == gpcd_pkg::GPCD_PC_FUNC_ADDR && REG_WDATA == 32'h0
    |-> ##2 PORTC_PIN_OE == 16'h0;
  endproperty
  a_c_in: assert property (p_c_in)
    else $error("port c input pins driven");
  property p_c_out;
    REG_WR && REG_ADDR == gpcd_pkg::GPCD_PC_DATA_ADDR |-> ##2
    (PORTC_PIN_OE != 16'hffff || PORTC_PIN_OUT == $past(wd_lo, 2));
  endproperty
  a_c_out: assert property (p_c_out)
    else $error("port c output not data value");
  property p_sync;
    !$past(SYS_RST) && !$past(SYS_RST, 2) |->
    VIDEO_DATA_IN == {$past(PORTD_PIN_IN, 2), $past(pc_hi, 2)};
  endproperty
  a_sync: assert property (p_sync)
    else $error("pin level not two flops late");
endmodule

bind gpcd_top gpcd_chk chk_u (.MCLK, .SYS_RST, .REG_ADDR, .REG_WDATA,
  .REG_WR, .REG_RD, .REG_RDATA, .PORTC_PIN_IN, .PORTC_PIN_OUT,
  .PORTC_PIN_OE, .PORTC_PULL_UP, .PORTC_PULL_DOWN, .PORTD_PIN_IN,
  .PORTD_PULL_UP, .PORTD_PULL_DOWN, .VIDEO_DATA_IN);

// ==== test/gpcd_top_tb.sv ====
// self-checking bench of the port c/d gpio block
`timescale 1ns/1ps
module gpcd_top_tb;
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [31:0] reg_addr = 32'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] rdata;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [15:0] c_out, c_oe, c_pu, c_pd, c_lvl, d_out, d_oe, d_pu, d_pd, d_lvl;
  logic [15:0] c_drv = 16'h0, c_en = 16'h0, d_drv = 16'h0, d_en = 16'h0;
  logic [23:0] pix = 24'h0;
  logic [23:0] vin;
  logic        vid_oe = 1'b0;
  logic [4:0]  ctl = 5'h0;
  int          error_cnt = 0, check_count = 0, cyc = 0;

  always #5 mclk = ~mclk;

  gpcd_top dut_u (.MCLK(mclk), .SYS_RST(sys_rst), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(rdata), .PORTC_PIN_IN(c_lvl), .PORTC_PIN_OUT(c_out),
    .PORTC_PIN_OE(c_oe), .PORTC_PULL_UP(c_pu), .PORTC_PULL_DOWN(c_pd),
    .PORTD_PIN_IN(d_lvl), .PORTD_PIN_OUT(d_out), .PORTD_PIN_OE(d_oe),
    .PORTD_PULL_UP(d_pu), .PORTD_PULL_DOWN(d_pd), .PIXEL_VIDEO_DATA(pix),
    .VIDEO_DATA_OE(vid_oe), .VIDEO_DATA_IN(vin), .PIXEL_DATA_ENABLE(ctl[4]),
    .VERTICAL_SYNC_OUT(ctl[3]), .HORIZONTAL_SYNC_OUT(ctl[2]),
    .PIXEL_CLOCK_OUT(ctl[1]), .LINE_END_OUT(ctl[0]));
  gpcd_board c_brd (.clk(mclk), .pin_out(c_out), .pin_oe(c_oe),
    .pull_up(c_pu), .pull_down(c_pd), .drv(c_drv), .drv_en(c_en),
    .level(c_lvl));
  gpcd_board d_brd (.clk(mclk), .pin_out(d_out), .pin_oe(d_oe),
    .pull_up(d_pu), .pull_down(d_pd), .drv(d_drv), .drv_en(d_en),
    .level(d_lvl));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk_reg(input logic [31:0] got, exp, input string m);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic chk_pin(input logic [15:0] got, exp, input string m);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, exp, input string m);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk_reg(rdata, exp, m);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    rd(gpcd_pkg::GPCD_PC_FUNC_ADDR, 32'h0, "c func");
    rd(gpcd_pkg::GPCD_PD_FUNC_ADDR, 32'h0, "d func");
    rd(gpcd_pkg::GPCD_PC_PULL_ADDR, 32'h0555_5555, "c pull");
    rd(gpcd_pkg::GPCD_PD_PULL_ADDR, 32'h0555_5555, "d pull");
    chk_pin(c_pd, 16'h3fff, "c pull down");
    chk_pin(d_pd, 16'h3fff, "d pull down");
    chk_pin(c_oe | d_oe, 16'h0, "oe");
  endtask
  task automatic t_spare();
    wr(gpcd_pkg::GPCD_PC_SPARE_ADDR, 32'hffff_ffff);
    wr(gpcd_pkg::GPCD_PD_SPARE_ADDR, 32'hffff_ffff);
    wr(32'h5600_00c0, 32'hffff_ffff);
    rd(gpcd_pkg::GPCD_PC_SPARE_ADDR, 32'h0, "c spare");
    rd(gpcd_pkg::GPCD_PD_SPARE_ADDR, 32'h0, "d spare");
    rd(32'h5600_00c0, 32'h0, "unmapped");
    rd(gpcd_pkg::GPCD_PD_FUNC_ADDR, 32'h0, "alias");
  endtask
  task automatic t_out();
    wr(gpcd_pkg::GPCD_PC_FUNC_ADDR, 32'h5555_5555);
    wr(gpcd_pkg::GPCD_PD_FUNC_ADDR, 32'h5555_5555);
    rd(gpcd_pkg::GPCD_PC_DATA_ADDR, 32'h0, "c data rst");
    rd(gpcd_pkg::GPCD_PD_DATA_ADDR, 32'h0, "d data rst");
    wr(gpcd_pkg::GPCD_PC_DATA_ADDR, 32'hffff_a5c3);
    wr(gpcd_pkg::GPCD_PD_DATA_ADDR, 32'hffff_3c5a);
    wt(2);
    chk_pin(c_oe & d_oe, 16'hffff, "out oe");
    chk_pin(c_out, 16'ha5c3, "c out");
    chk_pin(d_out, 16'h3c5a, "d out");
    rd(gpcd_pkg::GPCD_PC_DATA_ADDR, 32'ha5c3, "c data");
    rd(gpcd_pkg::GPCD_PD_DATA_ADDR, 32'h3c5a, "d data");
  endtask
  task automatic t_in();
    @(posedge mclk);
    c_drv <= 16'h1e87;
    d_drv <= 16'h9b21;
    c_en <= 16'hffff;
    d_en <= 16'hffff;
    wr(gpcd_pkg::GPCD_PC_FUNC_ADDR, 32'h0);
    wr(gpcd_pkg::GPCD_PD_FUNC_ADDR, 32'h0);
    wt(3);
    rd(gpcd_pkg::GPCD_PC_DATA_ADDR, 32'h1e87, "c in");
    rd(gpcd_pkg::GPCD_PD_DATA_ADDR, 32'h9b21, "d in");
    chk_reg({8'h0, vin}, 32'h009b_211e, "video in");
    wr(gpcd_pkg::GPCD_PC_FUNC_ADDR, 32'h0000_0055);
    wt(3);
    rd(gpcd_pkg::GPCD_PC_DATA_ADDR, 32'h1e83, "mixed");
  endtask
  task automatic t_alt();
    @(posedge mclk);
    pix <= 24'h5a_c396;
    vid_oe <= 1'b1;
    ctl <= 5'b10110;
    wr(gpcd_pkg::GPCD_PC_FUNC_ADDR, 32'haaaa_aaaa);
    wr(gpcd_pkg::GPCD_PD_FUNC_ADDR, 32'haaaa_aaaa);
    wt(2);
    chk_pin(c_oe, 16'hff1f, "c alt oe");
    chk_pin(c_out & c_oe, 16'h9616, "c alt out");
    chk_pin(d_oe, 16'hffff, "d alt oe");
    chk_pin(d_out, 16'h5ac3, "d alt out");
    @(posedge mclk);
    vid_oe <= 1'b0;
    wt(3);
    chk_pin(c_oe, 16'h001f, "c panel oe");
    chk_pin(d_oe, 16'h0, "d panel oe");
    chk_reg({8'h0, vin}, 32'h009b_211e, "panel in");
  endtask
  task automatic t_pull();
    wr(gpcd_pkg::GPCD_PC_PULL_ADDR, 32'he4e4_e4e4);
    wr(gpcd_pkg::GPCD_PD_PULL_ADDR, 32'haaaa_aaaa);
    wr(gpcd_pkg::GPCD_PC_FUNC_ADDR, 32'hffff_ffff);
    wt(2);
    chk_pin(c_pu, 16'h4444, "c up");
    chk_pin(c_pd, 16'h2222, "c down");
    chk_pin(d_pu, 16'hffff, "d up");
    chk_pin(d_pd, 16'h0, "d down");
    chk_pin(c_oe, 16'h0, "code 11 oe");
    rd(gpcd_pkg::GPCD_PC_PULL_ADDR, 32'he4e4_e4e4, "c pull rd");
  endtask

  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      error_cnt++;
      tally_and_finish();
    end
  end

  initial
  begin
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    t_reset();
    t_spare();
    t_out();
    t_in();
    t_alt();
    t_pull();
    tally_and_finish();
  end
endmodule
